/* File: wwd_pkg.sv */
// Constants, register map and field layout of the windowed watchdog timer.
// What this block does
// - Counter advances only on low-power oscillator ticks
// - Unserviced expiry issues a device reset
// - Postscaler selects among several time-out lengths
// - Expiry during Sleep wakes device
// - Writing enable one starts software watchdog
// - Enable zero stops only software-started watchdog
// - Enable bit reads one whenever watchdog runs
// - Postscaler shadow read-only, reloaded every reset
// - Bit one enables or disables window mode
// - Writing kick one restarts the time-out
// - Writing kick zero does nothing
// - Clear, set, invert aliases at 0x4/0x8/0xC
// - Unimplemented bits read zero, ignore writes
package wwd_pkg;

  // ------------------------------------------------------------------
  // Bus geometry and responses.
  // ------------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ------------------------------------------------------------------
  // Register byte offsets.
  // ------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_CLR = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_SET = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_INV = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_MASK = 8'h14;

  // ------------------------------------------------------------------
  // Control register fields.
  // ------------------------------------------------------------------
  localparam int unsigned ON_BIT = 15;
  localparam int unsigned PS_LSB = 2;
  localparam int unsigned PS_W = 5;
  localparam int unsigned WIN_BIT = 1;
  localparam int unsigned KICK_BIT = 0;
  localparam logic [31:0] CTRL_WR_MASK = 32'h0000_8003;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;

  // ------------------------------------------------------------------
  // Status and mask fields.
  // ------------------------------------------------------------------
  localparam int unsigned ST_W = 3;
  localparam int unsigned ST_EXPIRE = 0;
  localparam int unsigned ST_VIOL = 1;
  localparam int unsigned ST_WAKE = 2;
  localparam logic [ST_W-1:0] MASK_RST = 3'h0;

  // ------------------------------------------------------------------
  // Timing: the window opens when a quarter of the period is left.
  // ------------------------------------------------------------------
  localparam int unsigned WIN_SHIFT = 2;
  localparam logic [31:0] CNT_ONE = 32'h0000_0001;

endpackage

/* File: wwd_core_if.sv */
// Interface between the watchdog register front end and its counter core.
interface wwd_core_if;
  import wwd_pkg::*;
  logic run;               // Watchdog is active.
  logic kick;              // One-cycle restart request.
  logic window_en;         // Window mode is on.
  logic tick;              // Low-power oscillator tick.
  logic [PS_W-1:0] postscale; // Selected postscaler.
  logic expire;            // One-cycle period expiry pulse.
  logic violation;         // One-cycle early-kick pulse.
  modport front (output run, kick, window_en, tick, postscale, input expire, violation);
  modport core (input run, kick, window_en, tick, postscale, output expire, violation);
endinterface

/* File: wwd_core.sv */
// Counter core of the windowed watchdog: period, expiry and window check.
module wwd_core
  import wwd_pkg::*;
(
  // Clock, reset and enable.
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Link to the register front end.
  wwd_core_if.core cif
);

  // ------------------------------------------------------------------
  // Period arithmetic.
  // ------------------------------------------------------------------
  logic [31:0] count_q;  // Oscillator ticks since the last restart.
  logic [31:0] period;   // Ticks per time-out.
  logic [31:0] lim;      // Last count value before expiry.
  logic [31:0] open_at;  // First count at which a kick is allowed.
  logic expire_q;        // Registered expiry pulse.
  logic viol_q;          // Registered violation pulse.

  assign period = CNT_ONE << cif.postscale;
  assign lim = period - CNT_ONE;
  assign open_at = period - (period >> WIN_SHIFT);
  assign cif.expire = expire_q;
  assign cif.violation = viol_q;

  // Counter advances on oscillator ticks and restarts on a kick or expiry.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      count_q <= 32'h0000_0000;
      expire_q <= 1'b0;
      viol_q <= 1'b0;
    end else if (ce_i) begin
      expire_q <= 1'b0;
      viol_q <= 1'b0;
      if (!cif.run) begin
        count_q <= 32'h0000_0000;
      end else if (cif.kick) begin
        count_q <= 32'h0000_0000;
        viol_q <= cif.window_en && (count_q < open_at);
      end else if (cif.tick) begin
        if (count_q == lim) begin
          count_q <= 32'h0000_0000;
          expire_q <= 1'b1;
        end else begin
          count_q <= count_q + CNT_ONE;
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // Checks.
  // ------------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  AST_KICK_RESTARTS: assert property (ce_i && cif.run && cif.kick |=> count_q == 32'h0)
    else $error("kick did not restart the counter");
  AST_ONLY_TICKS: assert property (ce_i && cif.run && !cif.kick && !cif.tick |=> $stable(count_q))
    else $error("counter moved without an oscillator tick");
  AST_PERIOD_END: assert property (ce_i && cif.run && !cif.kick && cif.tick
      && count_q == lim |=> expire_q && count_q == 32'h0)
    else $error("period end did not expire");
  AST_EARLY_KICK: assert property (ce_i && cif.run && cif.kick && cif.window_en
      && count_q < open_at |=> viol_q)
    else $error("early kick not flagged");
  COV_EXPIRE: cover property (expire_q);
  COV_VIOL: cover property (viol_q);

endmodule

/* File: wwd_top.sv */
// Windowed watchdog timer top: AXI4-Lite registers, enable logic, events.
module wwd_top
  import wwd_pkg::*;
(
  // Clock, reset and enable.
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Configuration and device state.
  input wire logic cfg_enable_i,
  input wire logic [PS_W-1:0] config_postscaler_i,
  input wire logic sleep_i,
  input wire logic low_power_osc_tick_i,
  // AXI4-Lite write address channel.
  input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  // AXI4-Lite write data channel.
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  // AXI4-Lite write response channel.
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // AXI4-Lite read address channel.
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  // AXI4-Lite read data channel.
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Device outputs.
  output logic device_reset_o,
  output logic wake_o,
  output logic irq_o
);

  // ------------------------------------------------------------------
  // Declarations.
  // ------------------------------------------------------------------
  wwd_core_if cif ();               // Link to the counter core.
  logic awready_q;                  // Write address channel ready.
  logic wready_q;                   // Write data channel ready.
  logic bvalid_q;                   // Write response pending.
  logic [1:0] bresp_q;              // Write response code.
  logic arready_q;                  // Read address channel ready.
  logic rvalid_q;                   // Read data pending.
  logic [1:0] rresp_q;              // Read response code.
  logic [31:0] rdata_q;             // Read data.
  logic rd_ctrl_q;                  // Last read targeted the control word.
  logic aw_full_q;                  // Write address captured.
  logic w_full_q;                   // Write data captured.
  logic [ADDR_W-1:0] wr_addr_q;     // Captured write address.
  logic [31:0] wr_data_q;           // Captured write data.
  logic [3:0] wr_strb_q;            // Captured byte strobes.
  logic wr_do;                      // Write is performed this cycle.
  logic wr_ctrl;                    // Write hits the control word or an alias.
  logic [31:0] bmask;               // Byte strobes widened to bits.
  logic [31:0] ctrl_cur;            // Current writable control bits.
  logic [31:0] ctrl_new;            // Control bits after this write.
  logic sw_on_q;                    // Software enable.
  logic win_q;                      // Window mode enable.
  logic kick_q;                     // Restart pulse to the core.
  logic [PS_W-1:0] shadow_q;        // Postscaler shadow.
  logic active;                     // Watchdog is running.
  logic [ST_W-1:0] status_q;        // Sticky event flags.
  logic [ST_W-1:0] mask_q;          // Interrupt mask.
  logic [ST_W-1:0] events;          // Events raised this cycle.
  logic [31:0] rd_word;             // Read data being selected.
  logic rd_hit;                     // Read address is mapped.
  logic reset_q;                    // Device reset request.
  logic wake_q;                     // Wake request.
  logic irq_q;                      // Interrupt level.

  // ------------------------------------------------------------------
  // Outputs straight from flip-flops.
  // ------------------------------------------------------------------
  assign s_axi_awready_o = awready_q;
  assign s_axi_wready_o = wready_q;
  assign s_axi_bvalid_o = bvalid_q;
  assign s_axi_bresp_o = bresp_q;
  assign s_axi_arready_o = arready_q;
  assign s_axi_rvalid_o = rvalid_q;
  assign s_axi_rresp_o = rresp_q;
  assign s_axi_rdata_o = rdata_q;
  assign device_reset_o = reset_q;
  assign wake_o = wake_q;
  assign irq_o = irq_q;

  // ------------------------------------------------------------------
  // Core link.
  // ------------------------------------------------------------------
  // The watchdog runs if configuration or software turned it on.
  assign active = cfg_enable_i | sw_on_q;
  assign cif.run = active;
  assign cif.kick = kick_q;
  assign cif.window_en = win_q;
  assign cif.tick = low_power_osc_tick_i;
  assign cif.postscale = shadow_q;

  wwd_core u_core (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .ce_i      (ce_i),
    .cif       (cif.core)
  );

  // ------------------------------------------------------------------
  // Write channels.
  // ------------------------------------------------------------------
  // A write is done once address and data are both held and no response waits.
  assign wr_do = aw_full_q && w_full_q && !bvalid_q;
  assign wr_ctrl = (wr_addr_q == ADDR_CTRL) || (wr_addr_q == ADDR_CLR)
                || (wr_addr_q == ADDR_SET) || (wr_addr_q == ADDR_INV);
  assign bmask = {{8{wr_strb_q[3]}}, {8{wr_strb_q[2]}}, {8{wr_strb_q[1]}}, {8{wr_strb_q[0]}}};

  // Address and data are captured independently, in either order.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      wr_addr_q <= '0;
      wr_data_q <= 32'h0000_0000;
      wr_strb_q <= 4'h0;
    end else if (ce_i) begin
      if (s_axi_awvalid_i && awready_q) begin
        awready_q <= 1'b0;
        aw_full_q <= 1'b1;
        wr_addr_q <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && wready_q) begin
        wready_q <= 1'b0;
        w_full_q <= 1'b1;
        wr_data_q <= s_axi_wdata_i;
        wr_strb_q <= s_axi_wstrb_i;
      end
      if (wr_do) begin
        // Both halves held: answer and free the holding slots.
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= (wr_ctrl || wr_addr_q == ADDR_STATUS || wr_addr_q == ADDR_MASK)
                   ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready_i) begin
        // Response taken: open both channels for the next write.
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------------
  // Control register.
  // ------------------------------------------------------------------
  // Work out the writable bits after a write to the word or an alias.
  always_comb begin
    ctrl_cur = CTRL_RST;
    ctrl_cur[ON_BIT] = sw_on_q;
    ctrl_cur[WIN_BIT] = win_q;
    unique case (wr_addr_q)
      ADDR_CLR: ctrl_new = ctrl_cur & ~(wr_data_q & bmask);
      ADDR_SET: ctrl_new = ctrl_cur | (wr_data_q & bmask);
      ADDR_INV: ctrl_new = ctrl_cur ^ (wr_data_q & bmask);
      default: ctrl_new = (ctrl_cur & ~bmask) | (wr_data_q & bmask);
    endcase
    // Only the enable, window and kick bits can take a write.
    ctrl_new = ctrl_new & CTRL_WR_MASK;
  end

  // Enable, window mode and kick take their new values on a control write.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      sw_on_q <= CTRL_RST[ON_BIT];
      win_q <= CTRL_RST[WIN_BIT];
      kick_q <= 1'b0;
    end else if (ce_i) begin
      kick_q <= 1'b0;
      if (wr_do && wr_ctrl) begin
        sw_on_q <= ctrl_new[ON_BIT];
        win_q <= ctrl_new[WIN_BIT];
        // A one restarts the period; a zero is simply ignored.
        kick_q <= ctrl_new[KICK_BIT] && active;
      end
    end
  end

  // The shadow is reloaded from configuration on every reset.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      shadow_q <= config_postscaler_i;
    end
  end

  // ------------------------------------------------------------------
  // Events, status, mask and interrupt.
  // ------------------------------------------------------------------
  assign events = {cif.expire && sleep_i, cif.violation, cif.expire};

  // Sticky flags; a new event beats a write-one clear in the same cycle.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      status_q <= '0;
      mask_q <= MASK_RST;
    end else if (ce_i) begin
      if (wr_do && wr_addr_q == ADDR_STATUS) begin
        status_q <= (status_q & ~(wr_data_q[ST_W-1:0] & bmask[ST_W-1:0])) | events;
      end else begin
        status_q <= status_q | events;
      end
      if (wr_do && wr_addr_q == ADDR_MASK) begin
        mask_q <= (mask_q & ~bmask[ST_W-1:0]) | (wr_data_q[ST_W-1:0] & bmask[ST_W-1:0]);
      end
    end
  end

  // Expiry wakes a sleeping device and resets a running one.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      reset_q <= 1'b0;
      wake_q <= 1'b0;
      irq_q <= 1'b0;
    end else if (ce_i) begin
      reset_q <= (cif.expire && !sleep_i) || cif.violation;
      wake_q <= cif.expire && sleep_i;
      irq_q <= |(status_q & mask_q);
    end
  end

  // ------------------------------------------------------------------
  // Read channel.
  // ------------------------------------------------------------------
  // Select the word for a read; unused bits stay zero.
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    unique case (s_axi_araddr_i)
      ADDR_CTRL, ADDR_CLR, ADDR_SET, ADDR_INV: begin
        rd_word[ON_BIT] = active;
        rd_word[PS_LSB +: PS_W] = shadow_q;
        rd_word[WIN_BIT] = win_q;
      end
      ADDR_STATUS: rd_word[ST_W-1:0] = status_q;
      ADDR_MASK: rd_word[ST_W-1:0] = mask_q;
      default: rd_hit = 1'b0;
    endcase
  end

  // One read at a time: answer one cycle after the address is taken.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= 32'h0000_0000;
      rd_ctrl_q <= 1'b0;
    end else if (ce_i) begin
      if (s_axi_arvalid_i && arready_q) begin
        arready_q <= 1'b0;
        rvalid_q <= 1'b1;
        rdata_q <= rd_word;
        rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        rd_ctrl_q <= s_axi_araddr_i == ADDR_CTRL;
      end else if (rvalid_q && s_axi_rready_i) begin
        rvalid_q <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------------
  // Checks.
  // ------------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  AST_ENABLE_READ: assert property (ce_i && s_axi_arvalid_i && arready_q
      && s_axi_araddr_i == ADDR_CTRL |=> rvalid_q && rdata_q[ON_BIT] == $past(active))
    else $error("enable bit read does not show activity");
  AST_CFG_HOLDS_RUN: assert property (ce_i && cfg_enable_i && s_axi_arvalid_i && arready_q
      |=> rdata_q[ON_BIT] || !rd_ctrl_q)
    else $error("configured watchdog not shown as running");
  AST_SW_START: assert property (ce_i && wr_do && wr_addr_q == ADDR_SET
      && wr_data_q[ON_BIT] && wr_strb_q[1] |=> active && sw_on_q)
    else $error("set of enable did not start watchdog");
  AST_WIN_SET: assert property (ce_i && wr_do && wr_addr_q == ADDR_SET
      && wr_data_q[WIN_BIT] && wr_strb_q[0] |=> win_q)
    else $error("set alias did not set window mode");
  AST_WIN_CLR: assert property (ce_i && wr_do && wr_addr_q == ADDR_CTRL
      && !wr_data_q[WIN_BIT] && wr_strb_q[0] |=> !win_q)
    else $error("window mode not cleared");
  AST_RSVD_ZERO: assert property (rvalid_q && rd_ctrl_q
      |-> rdata_q[31:16] == 16'h0000 && rdata_q[14:7] == 8'h00 && !rdata_q[KICK_BIT])
    else $error("unimplemented or kick bit reads nonzero");
  AST_KICK_PULSE: assert property (ce_i && kick_q |=> !kick_q)
    else $error("kick stuck high");
  AST_EXPIRE_RESET: assert property (ce_i && cif.expire && !sleep_i |=> reset_q && !wake_q)
    else $error("expiry did not reset device");
  AST_EXPIRE_WAKE: assert property (ce_i && cif.expire && sleep_i
      |=> wake_q ##1 (!wake_q || !$past(ce_i) || $past(cif.expire && sleep_i)))
    else $error("expiry in sleep did not wake device");
  AST_VIOL_RESET: assert property (ce_i && cif.violation |=> reset_q)
    else $error("window violation did not reset device");
  AST_SHADOW_LOAD: assert property (disable iff (1'b0) rst_i |=> shadow_q == $past(config_postscaler_i))
    else $error("shadow not loaded at reset");
  COV_WAKE: cover property (wake_q);
  COV_RESET: cover property (reset_q);
  COV_IRQ: cover property (irq_q);

endmodule

/* File: wwd_top_tb.sv */
// Self-checking testbench for the windowed watchdog timer top.
module wwd_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import wwd_pkg::*;

  // ----------------------------------------------------------------
  // Stimulus and observed signals.
  // ----------------------------------------------------------------
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cfg_en = 1'b0;
  logic [PS_W-1:0] cfg_ps = 5'h03; // Period of eight ticks keeps runs short.
  logic sleep = 1'b0;
  logic tick = 1'b0;
  logic ce = 1'b1; // Clock enable, dropped once to check that state freezes.
  logic [3:0] wstrb = 4'hF; // Write byte strobes.
  logic [ADDR_W-1:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, dev_rst, wake, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, rd_val;
  int failures = 0;
  int n_compared = 0;
  int cyc = 0;
  int rst_pulses = 0;
  int wake_pulses = 0;

  // ----------------------------------------------------------------
  // Clock, pulse counters and hang guard.
  // ----------------------------------------------------------------
  always #2 clk = ~clk;

  // Pulses last one cycle, so counting high cycles counts events.
  always @(posedge clk) begin
    cyc++;
    if (dev_rst === 1'b1) rst_pulses++;
    if (wake === 1'b1) wake_pulses++;
    if (cyc == 20000) begin
      failures++;
      final_report();
    end
  end

  wwd_top dut_u (.ref_clk_i(clk), .rst_i(rst), .ce_i(ce), .cfg_enable_i(cfg_en),
    .config_postscaler_i(cfg_ps), .sleep_i(sleep), .low_power_osc_tick_i(tick),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awv), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wv),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arv),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .device_reset_o(dev_rst),
    .wake_o(wake), .irq_o(irq));

  // ----------------------------------------------------------------
  // Shared tasks.
  // ----------------------------------------------------------------
  // Compares one observed value with its expectation.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Prints the verdict and ends the run.
  task automatic final_report();
    if (failures == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // One write; address and data are released as each is taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge clk);
      if (awv && awready) awv <= 1'b0;
      if (wv && wready) wv <= 1'b0;
      if (bvalid === 1'b1) begin
        chk({30'h0, bresp}, {30'h0, er});
        bready <= 1'b0;
        break;
      end
    end
  endtask

  // One read; the response code is checked, the data handed back.
  task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
    @(posedge clk);
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge clk);
      if (arv && arready) arv <= 1'b0;
      if (rvalid === 1'b1) begin
        chk({30'h0, rresp}, {30'h0, er});
        d = rdata;
        rready <= 1'b0;
        break;
      end
    end
  endtask

  // Gives n oscillator ticks, then lets the event pipeline settle.
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk) tick <= 1'b1;
      @(posedge clk) tick <= 1'b0;
    end
    repeat (4) @(posedge clk);
  endtask

  // Restarts the period through the invert alias, leaving other bits alone.
  task automatic kick();
    wr(ADDR_INV, 32'h0000_0001, RESP_OKAY);
  endtask

  // ----------------------------------------------------------------
  // Test sequence.
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd(ADDR_CTRL, RESP_OKAY, rd_val);
    chk(rd_val, 32'h0000_000C);
    rd(ADDR_MASK, RESP_OKAY, rd_val);
    chk(rd_val, 32'h0000_0000);
    ticks(10);
    chk(rst_pulses, 0);
    wr(ADDR_CTRL, 32'hFFFF_FFFF, RESP_OKAY);
    rd(ADDR_CTRL, RESP_OKAY, rd_val);
    chk(rd_val, 32'h0000_800E);
    wr(ADDR_CLR, 32'h0000_0002, RESP_OKAY);
    rd(ADDR_CTRL, RESP_OKAY, rd_val);
    chk(rd_val, 32'h0000_800C);
    wr(ADDR_INV, 32'h0000_8002, RESP_OKAY);
    rd(ADDR_CTRL, RESP_OKAY, rd_val);
    chk(rd_val, 32'h0000_000E);
    wr(ADDR_SET, 32'h0000_8000, RESP_OKAY);
    wr(ADDR_CLR, 32'h0000_0002, RESP_OKAY);
    rd(ADDR_CTRL, RESP_OKAY, rd_val);
    chk(rd_val, 32'h0000_800C);
    wr(8'h18, 32'hFFFF_FFFF, RESP_SLVERR);
    rd(8'h18, RESP_SLVERR, rd_val);
    chk(rd_val, 32'h0000_0000);
    // Only byte zero strobed: the enable bit must survive the clear alias.
    wstrb <= 4'h1;
    wr(ADDR_CLR, 32'h0000_8000, RESP_OKAY);
    wstrb <= 4'hF;
    rd(ADDR_CTRL, RESP_OKAY, rd_val);
    chk(rd_val, 32'h0000_800C);
    wr(ADDR_MASK, 32'h0000_0007, RESP_OKAY);
    // Period of eight ticks: two kicks inside it, then a zero write.
    kick();
    repeat (200) @(posedge clk);
    chk(rst_pulses, 0);
    ticks(7);
    kick();
    ticks(7);
    chk(rst_pulses, 0);
    wr(ADDR_CTRL, 32'h0000_8000, RESP_OKAY);
    ticks(1);
    chk(rst_pulses, 1);
    chk(irq, 1'b1);
    rd(ADDR_STATUS, RESP_OKAY, rd_val);
    chk(rd_val & 32'h0000_0001, 32'h0000_0001);
    wr(ADDR_STATUS, 32'h0000_0007, RESP_OKAY);
    repeat (3) @(posedge clk);
    chk(irq, 1'b0);
    // Window mode: an early kick is a violation, a late one is not.
    kick();
    wr(ADDR_SET, 32'h0000_0002, RESP_OKAY);
    ticks(2);
    kick();
    repeat (4) @(posedge clk);
    chk(rst_pulses, 2);
    rd(ADDR_STATUS, RESP_OKAY, rd_val);
    chk(rd_val & 32'h0000_0002, 32'h0000_0002);
    wr(ADDR_CLR, 32'h0000_0002, RESP_OKAY);
    kick();
    wr(ADDR_SET, 32'h0000_0002, RESP_OKAY);
    ticks(6);
    kick();
    ticks(6);
    kick();
    repeat (4) @(posedge clk);
    chk(rst_pulses, 2);
    wr(ADDR_CLR, 32'h0000_0002, RESP_OKAY);
    // Expiry while asleep wakes the device instead of resetting it.
    sleep <= 1'b1;
    kick();
    ticks(8);
    chk(wake_pulses, 1);
    chk(rst_pulses, 2);
    sleep <= 1'b0;
    // Second reset: new shadow value and watchdog forced on by config.
    cfg_ps <= 5'h02;
    cfg_en <= 1'b1;
    rst <= 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd(ADDR_CTRL, RESP_OKAY, rd_val);
    chk(rd_val, 32'h0000_8008);
    wr(ADDR_CLR, 32'h0000_8000, RESP_OKAY);
    rd(ADDR_CTRL, RESP_OKAY, rd_val);
    chk(rd_val, 32'h0000_8008);
    kick();
    ticks(4);
    chk(rst_pulses, 3);
    chk(irq, 1'b0);
    // With the clock enable low, ticks must not advance the counter.
    ce <= 1'b0;
    ticks(4);
    chk(rst_pulses, 3);
    ce <= 1'b1;
    ticks(4);
    chk(rst_pulses, 4);
    final_report();
  end
endmodule
